/* File: crcfa_pkg.sv */
// crcfa_pkg: constants and carrier types for the flash crc sequencer block
// assumes an 8-bit sfr bus with 8-bit addresses and a byte-wide flash port
package crcfa_pkg;
	localparam logic [7:0] CONTROL_OFFSET = 8'h92;
	localparam logic [7:0] INPUT_OFFSET = 8'h93;
	localparam logic [7:0] BIT_REVERSE_OFFSET = 8'h95;
	localparam logic [7:0] AUTO_CONTROL_OFFSET = 8'h96;
	localparam logic [7:0] SECTOR_COUNT_OFFSET = 8'h97;
	localparam int AUTO_EN_BIT = 7;
	localparam int COMPLETE_BIT = 6;
	localparam int POLY_SEL_BIT = 4;
	localparam int INIT_BIT = 3;
	localparam int SET_VAL_BIT = 2;
	localparam int PAGE_SHIFT = 9;
	localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
	localparam logic [31:0] POLY16 = 32'h0000_1021;
	localparam logic [31:0] RESULT_ZERO = 32'h0000_0000;
	localparam logic [31:0] RESULT_ONES = 32'hFFFF_FFFF;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [5:0] FIELD_RESET = 6'h00;
	localparam logic COMPLETE_RESET = 1'b1;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crcfa_sfr_t;
	typedef enum logic [1:0] {
		CRCFA_IDLE = 2'b00,
		CRCFA_REQ = 2'b01,
		CRCFA_FOLD = 2'b11
	} crcfa_state_t;
endpackage

/* File: crcfa_fold.sv */
// crcfa_fold: folds one byte into a crc result, msb first
// assumes the caller registers the result
module crcfa_fold
(
	input wire logic [31:0] i_crc,
	input wire logic [7:0] i_byte,
	input wire logic i_poly16,
	output logic [31:0] o_crc
);
	logic [31:0] stage [0:8];
	assign stage[0] = i_crc;
	genvar b;
	generate
		for (b = 0; b < 8; b++)
		begin : g_bit
			logic fb32;
			logic fb16;
			assign fb32 = stage[b][31] ^ i_byte[7-b];
			assign fb16 = stage[b][15] ^ i_byte[7-b];
			assign stage[b+1] = i_poly16 ?
				{16'h0000, stage[b][14:0], 1'b0} ^
				(fb16 ? crcfa_pkg::POLY16 : 32'h0000_0000) :
				{stage[b][30:0], 1'b0} ^
				(fb32 ? crcfa_pkg::POLY32 : 32'h0000_0000);
		end
	endgenerate
	assign o_crc = stage[8];
endmodule // crcfa_fold

/* File: crcfa_top.sv */
// crcfa_top: automatic flash crc sequencer, crc engine core, bit reverse reg
// assumes a one-cycle sfr strobe bus and flash data valid one cycle after
// the read strobe
// Functional notes
// - with auto enable set, any control write starts a flash crc run
// - completion flag is zero during a run, one again when finished
// - core is stalled throughout the run, so firmware reads see one
// - first sector byte address is start field times page size
// - page size is 512 bytes
// - six-bit count field sets number of sectors in the run minus one
// - last sector begins at (start plus count) times page size
// - upper two bits of count register read zero, writes ignored
// - bit reverse register reads back the written byte reversed
// - select bit zero gives 32-bit poly, one gives 16-bit poly
// - writing init loads result with zeros or ones per set value
module crcfa_top
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire crcfa_pkg::crcfa_sfr_t i_sfr,
	output logic [7:0] o_sfr_rdata,
	output logic o_cpu_stall,
	output logic o_flash_rd,
	output logic [15:0] o_flash_addr,
	input wire logic [7:0] i_flash_data,
	output logic [31:0] o_crc_result
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [31:0] crc_reg, crc_next, crc_folded;
	logic [7:0] fold_byte;
	logic [7:0] flip_reg, flip_next;
	logic auto_en_reg, auto_en_next;
	logic complete_reg, complete_next;
	logic [5:0] start_reg, start_next;
	logic [5:0] count_reg, count_next;
	logic [15:0] addr_reg, addr_next;
	logic [15:0] end_reg, end_next;
	logic [7:0] rdata_reg, rdata_next;
	crcfa_pkg::crcfa_state_t state_reg, state_next;
	logic wr_ctrl, wr_in, wr_flip, wr_auto, wr_cnt;

	assign wr_ctrl = i_sfr.wr && i_sfr.addr == crcfa_pkg::CONTROL_OFFSET;
	assign wr_in = i_sfr.wr && i_sfr.addr == crcfa_pkg::INPUT_OFFSET;
	assign wr_flip = i_sfr.wr && i_sfr.addr == crcfa_pkg::BIT_REVERSE_OFFSET;
	assign wr_auto = i_sfr.wr && i_sfr.addr == crcfa_pkg::AUTO_CONTROL_OFFSET;
	assign wr_cnt = i_sfr.wr && i_sfr.addr == crcfa_pkg::SECTOR_COUNT_OFFSET;

	assign fold_byte = (state_reg == crcfa_pkg::CRCFA_FOLD) ?
		i_flash_data : i_sfr.wdata;

	crcfa_fold u_fold
	(
		.i_crc(crc_reg),
		.i_byte(fold_byte),
		.i_poly16(ctrl_reg[crcfa_pkg::POLY_SEL_BIT]),
		.o_crc(crc_folded)
	);

	always_comb
	begin
		ctrl_next = ctrl_reg;
		crc_next = crc_reg;
		flip_next = flip_reg;
		auto_en_next = auto_en_reg;
		complete_next = complete_reg;
		start_next = start_reg;
		count_next = count_reg;
		addr_next = addr_reg;
		end_next = end_reg;
		state_next = state_reg;
		if (wr_flip)
			flip_next = i_sfr.wdata;
		if (wr_auto)
		begin
			auto_en_next = i_sfr.wdata[crcfa_pkg::AUTO_EN_BIT];
			start_next = i_sfr.wdata[5:0];
		end
		if (wr_cnt)
			count_next = i_sfr.wdata[5:0];
		if (wr_in)
			crc_next = crc_folded;
		if (wr_ctrl)
		begin
			ctrl_next = {3'b000, i_sfr.wdata[4], 1'b0, i_sfr.wdata[2:0]};
			if (i_sfr.wdata[crcfa_pkg::INIT_BIT])
				crc_next = i_sfr.wdata[crcfa_pkg::SET_VAL_BIT] ?
					crcfa_pkg::RESULT_ONES : crcfa_pkg::RESULT_ZERO;
		end
		case (state_reg)
			crcfa_pkg::CRCFA_IDLE:
			begin
				if (wr_ctrl && auto_en_reg)
				begin
					addr_next = {1'b0, start_reg, 9'h000};
					// last sector begins at (start+count)*page, so it ends
					// one page further on
					end_next = 16'({7'h00, start_reg} + {7'h00, count_reg}
						+ 13'h0001) << crcfa_pkg::PAGE_SHIFT;
					complete_next = 1'b0;
					state_next = crcfa_pkg::CRCFA_REQ;
				end
			end
			crcfa_pkg::CRCFA_REQ:
				state_next = crcfa_pkg::CRCFA_FOLD;
			crcfa_pkg::CRCFA_FOLD:
			begin
				crc_next = crc_folded;
				addr_next = addr_reg + 16'h0001;
				if (addr_reg + 16'h0001 == end_reg)
				begin
					complete_next = 1'b1;
					state_next = crcfa_pkg::CRCFA_IDLE;
				end
				else
					state_next = crcfa_pkg::CRCFA_REQ;
			end
			default:
				state_next = crcfa_pkg::CRCFA_IDLE;
		endcase
	end

	always_comb
	begin
		rdata_next = crcfa_pkg::BYTE_RESET;
		case (i_sfr.addr)
			crcfa_pkg::CONTROL_OFFSET: rdata_next = ctrl_reg;
			crcfa_pkg::BIT_REVERSE_OFFSET:
				rdata_next = {<<{flip_reg}};
			crcfa_pkg::AUTO_CONTROL_OFFSET:
				rdata_next = {auto_en_reg, complete_reg, start_reg};
			crcfa_pkg::SECTOR_COUNT_OFFSET:
				rdata_next = {2'b00, count_reg};
			default: rdata_next = crcfa_pkg::BYTE_RESET;
		endcase
		if (!i_sfr.rd)
			rdata_next = rdata_reg;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl_reg <= crcfa_pkg::BYTE_RESET;
			crc_reg <= crcfa_pkg::RESULT_ZERO;
			flip_reg <= crcfa_pkg::BYTE_RESET;
			auto_en_reg <= 1'b0;
			complete_reg <= crcfa_pkg::COMPLETE_RESET;
			start_reg <= crcfa_pkg::FIELD_RESET;
			count_reg <= crcfa_pkg::FIELD_RESET;
			addr_reg <= 16'h0000;
			end_reg <= 16'h0000;
			rdata_reg <= crcfa_pkg::BYTE_RESET;
			state_reg <= crcfa_pkg::CRCFA_IDLE;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			crc_reg <= crc_next;
			flip_reg <= flip_next;
			auto_en_reg <= auto_en_next;
			complete_reg <= complete_next;
			start_reg <= start_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			end_reg <= end_next;
			rdata_reg <= rdata_next;
			state_reg <= state_next;
		end
	end

	assign o_sfr_rdata = rdata_reg;
	assign o_cpu_stall = state_reg != crcfa_pkg::CRCFA_IDLE;
	assign o_flash_rd = state_reg == crcfa_pkg::CRCFA_REQ;
	assign o_flash_addr = addr_reg;
	assign o_crc_result = crc_reg;

	a_run_start: assert property (@(posedge i_mclk) disable iff (i_rst)
		state_reg == crcfa_pkg::CRCFA_IDLE && wr_ctrl && auto_en_reg
		|=> o_cpu_stall && !complete_reg && o_flash_rd)
		else $error("auto run did not start");
	a_no_start: assert property (@(posedge i_mclk) disable iff (i_rst)
		state_reg == crcfa_pkg::CRCFA_IDLE && !(wr_ctrl && auto_en_reg)
		|=> !o_cpu_stall)
		else $error("run started without enable");
	a_done_low: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_cpu_stall |-> !complete_reg)
		else $error("complete flag high during run");
	a_done_back: assert property (@(posedge i_mclk) disable iff (i_rst)
		$fell(o_cpu_stall) |-> complete_reg)
		else $error("complete flag not restored");
	a_first_addr: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_cpu_stall) |-> o_flash_addr == {1'b0, start_reg, 9'h000})
		else $error("wrong first sector address");
	sequence s_fetch;
		o_flash_rd ##1 !o_flash_rd;
	endsequence
	a_addr_step: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_flash_rd && o_cpu_stall ##1 o_cpu_stall ##1 o_cpu_stall
		|-> o_flash_addr == $past(o_flash_addr, 2) + 16'h0001)
		else $error("flash address not ascending");
	a_fetch_shape: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_flash_rd |-> s_fetch)
		else $error("fetch strobe longer than one cycle");
	a_cnt_upper: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_sfr.rd && i_sfr.addr == crcfa_pkg::SECTOR_COUNT_OFFSET
		|=> o_sfr_rdata[7:6] == 2'b00)
		else $error("count upper bits not zero");
	a_flip_read: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_sfr.rd && i_sfr.addr == crcfa_pkg::BIT_REVERSE_OFFSET
		|=> o_sfr_rdata[7] == $past(flip_reg[0])
		&& o_sfr_rdata[0] == $past(flip_reg[7]))
		else $error("bit reverse readback wrong");
	a_init_val: assert property (@(posedge i_mclk) disable iff (i_rst)
		wr_ctrl && i_sfr.wdata[crcfa_pkg::INIT_BIT] && !o_cpu_stall
		|=> crc_reg == {32{$past(i_sfr.wdata[crcfa_pkg::SET_VAL_BIT])}})
		else $error("init value wrong");
endmodule // crcfa_top

/* File: crcfa_flash_model.sv */
// crcfa_flash_model: byte-wide flash that answers one cycle after a strobe
// assumes strobe and address come from the sequencer on the same clock
module crcfa_flash_model
(
	input wire logic i_mclk,
	input wire logic i_rd,
	input wire logic [15:0] i_addr,
	output logic [7:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_data = 8'h00;
	// data stands one cycle only, then turns to garbage
	always @(posedge i_mclk)
	begin
		if (i_rd)
			o_data <= i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
		else
			o_data <= ~o_data;
	end
endmodule // crcfa_flash_model

/* File: test_crcfa_top.sv */
// test_crcfa_top: self-checking bench for the flash crc sequencer
// assumes the flash model answers the design's read strobes
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module test_crcfa_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	crcfa_pkg::crcfa_sfr_t sfr = '0;
	logic [7:0] rdata, fdata, q;
	logic stall, fl_rd;
	logic [15:0] fl_addr, exp_addr = 16'h0000;
	logic [31:0] crc;
	int n_fail = 0, tests_run = 0, n_fetch = 0;
	always #20 clk = ~clk;
	crcfa_top DUT (.i_mclk(clk), .i_rst(rst), .i_sfr(sfr),
		.o_sfr_rdata(rdata), .o_cpu_stall(stall), .o_flash_rd(fl_rd),
		.o_flash_addr(fl_addr), .i_flash_data(fdata), .o_crc_result(crc));
	crcfa_flash_model flash (.i_mclk(clk), .i_rd(fl_rd), .i_addr(fl_addr),
		.o_data(fdata));
	function automatic logic [31:0] fold(input logic [31:0] c,
		input logic [7:0] b, input logic p16);
		logic [31:0] r;
		r = p16 ? {c[15:0] ^ {b, 8'h00}, 16'h0000} : c ^ {b, 24'h00_0000};
		for (int i = 0; i < 8; i++)
			r = r[31] ? (r << 1) ^ (p16 ? 32'h1021_0000 : 32'h04C1_1DB7) : r << 1;
		return p16 ? {16'h0000, r[31:16]} : r;
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr <= {2'b10, a, d};
		@(posedge clk);
		sfr.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr <= {2'b01, a, 8'h00};
		@(posedge clk);
		sfr.rd <= 1'b0;
		#1 q = rdata;
		`CHK(q, e)
	endtask
	always @(posedge clk)
	begin
		if (fl_rd === 1'b1)
		begin
			`CHK(fl_addr, exp_addr)
			exp_addr = exp_addr + 16'h0001;
			n_fetch++;
		end
	end
	task t_reset;
		rd(8'h96, 8'h40);
		rd(8'h97, 8'h00);
		rd(8'h95, 8'h00);
		rd(8'h90, 8'h00);
	endtask
	task t_regs;
		wr(8'h95, 8'h05);
		rd(8'h95, 8'hA0);
		wr(8'h95, 8'hC0);
		rd(8'h95, 8'h03);
		wr(8'h97, 8'hFF);
		rd(8'h97, 8'h3F);
		wr(8'h96, 8'h3F);
		rd(8'h96, 8'h7F);
	endtask
	task t_crc;
		wr(8'h92, 8'h08);
		#1 `CHK(crc, 32'h0000_0000)
		wr(8'h92, 8'h0C);
		#1 `CHK(crc, 32'hFFFF_FFFF)
		wr(8'h93, 8'h31);
		#1 `CHK(crc, fold(32'hFFFF_FFFF, 8'h31, 1'b0))
		wr(8'h92, 8'h1C);
		wr(8'h93, 8'h31);
		#1 `CHK(crc[15:0], fold(32'hFFFF_FFFF, 8'h31, 1'b1))
	endtask
	task t_auto;
		logic [31:0] e;
		int i;
		e = 32'hFFFF_FFFF;
		for (i = 1024; i < 2048; i++)
			e = fold(e, i[7:0] ^ i[15:8] ^ 8'h5A, 1'b0);
		wr(8'h96, 8'h82);
		wr(8'h97, 8'h01);
		exp_addr = 16'h0400;
		n_fetch = 0;
		wr(8'h92, 8'h0C);
		#1 `CHK(stall, 1'b1)
		repeat (50) @(posedge clk);
		rd(8'h96, 8'h82);
		`CHK(stall, 1'b1)
		for (i = 0; i < 5000 && stall !== 1'b0; i++)
			@(posedge clk);
		#1 `CHK(n_fetch, 1024)
		`CHK(stall, 1'b0)
		`CHK(crc, e)
		// bit reverse write and checked readback once the stalled core resumes
		wr(8'h95, 8'h01);
		rd(8'h95, 8'h80);
		rd(8'h96, 8'hC2);
	endtask
	task t_cut;
		wr(8'h96, 8'h81);
		exp_addr = 16'h0200;
		wr(8'h92, 8'h00);
		#1 `CHK(stall, 1'b1)
		repeat (20) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 `CHK(stall, 1'b0)
		`CHK(crc, 32'h0000_0000)
		rd(8'h96, 8'h40);
		rd(8'h97, 8'h00);
	endtask
	task close_out;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#(40 * 20000);
		n_fail++;
		close_out;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_crc;
		t_auto;
		t_cut;
		close_out;
	end
endmodule // test_crcfa_top
